/* File: src/dlci_pkg.sv */
/*
 * Package for the deframer link configuration and interrupt vector block:
 * register offsets, field positions, reset values and the carrier structs.
 * Assumes an 8-bit serial control port in front of it that presents one
 * decoded register access per clock.
 */
package dlci_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register offsets
    localparam int unsigned ADDR_W = 12;
    localparam logic [11:0] OFS_OCTETS_PER_FRAME = 12'h476;
    localparam logic [11:0] OFS_LINK_TEST_CTRL   = 12'h477;
    localparam logic [11:0] OFS_ALIGN_MF_COUNT   = 12'h478;
    localparam logic [11:0] OFS_LINK_IRQ_VECTOR  = 12'h47A;

    ////////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [7:0] RST_OCTETS_PER_FRAME = 8'h01;
    localparam logic [7:0] RST_LINK_TEST_CTRL   = 8'h00;
    localparam logic [7:0] RST_ALIGN_MF_COUNT   = 8'h01;
    localparam logic [7:0] RST_LINK_IRQ_ENABLE  = 8'h00;

    // Legal octets-per-frame settings
    localparam logic [7:0] OCTETS_ONE  = 8'h01;
    localparam logic [7:0] OCTETS_TWO  = 8'h02;
    localparam logic [7:0] OCTETS_FOUR = 8'h04;

    ////////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int unsigned BIT_ALIGNMENT_TEST_MODE = 7;
    localparam int unsigned BIT_THRESHOLD_GATE_EN   = 3;

    localparam int unsigned BIT_DISPARITY_ERR   = 7;
    localparam int unsigned BIT_TABLE_MISS      = 6;
    localparam int unsigned BIT_STRAY_CONTROL   = 5;
    localparam int unsigned BIT_IRQ_RESERVED    = 4;
    localparam int unsigned BIT_LANE_ALIGN_FAIL = 3;
    localparam int unsigned BIT_CHECKSUM_FAIL   = 2;
    localparam int unsigned BIT_FRAME_LOCK_FAIL = 1;
    localparam int unsigned BIT_GROUP_LOCK_FAIL = 0;

    // Implemented bits of the interrupt vector
    localparam logic [7:0] IRQ_VECTOR_USED = 8'hEF;

    // Sync-request gate positions on the gate input
    localparam int unsigned GATE_DISPARITY = 2;
    localparam int unsigned GATE_TABLE     = 1;
    localparam int unsigned GATE_STRAY     = 0;

    // Sequence length is the field times four
    localparam int unsigned ALIGN_MF_SHIFT = 2;
    localparam int unsigned NUM_SOURCES    = 8;

    ////////////////////////////////////////////////////////////////////////////
    // Carriers
    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [ADDR_W-1:0] addr;
        logic [7:0]        wdata;
    } dlci_reg_req_s;

    typedef struct packed {
        logic       valid;
        logic [7:0] rdata;
    } dlci_reg_rsp_s;

    typedef struct packed {
        logic [7:0] octets_per_frame;
        logic [7:0] link_test_ctrl;
        logic [7:0] alignment_multiframes_div4;
        logic [7:0] link_irq_enable;
        logic [7:0] link_irq_pending;
        logic       irq_n;
        logic       link_sync_request;
        logic [9:0] alignment_multiframes;
        dlci_reg_rsp_s rsp;
    } dlci_state_s;

endpackage : dlci_pkg

/* File: src/dlci_lane_or.sv */
/*
 * Collapses the per-lane interrupt sources of each error class into one
 * bit per class, in the layout of the interrupt vector.
 * Assumes each per-lane source is a level held by the lane logic until its
 * own per-lane reset clears it.
 */
module dlci_lane_or #(
    parameter int unsigned LANES = 8
) (
    // Per-lane sources, one row per vector bit
    input  wire logic [dlci_pkg::NUM_SOURCES-1:0][LANES-1:0] lane_src_i,
    // Any-lane summary
    output logic      [dlci_pkg::NUM_SOURCES-1:0]            any_lane_o
);

    ////////////////////////////////////////////////////////////////////////////
    for (genvar g = 0; g < dlci_pkg::NUM_SOURCES; g++) begin : g_src
        assign any_lane_o[g] = |lane_src_i[g];
    end

endmodule : dlci_lane_or

/* File: src/dlci_top.sv */
/*
 * Link configuration and interrupt vector registers of the deframer.
 * Holds the frame size, alignment test mode, threshold gating enable and
 * alignment sequence length, gathers per-lane error sources into one flag
 * vector with enables and drives the active-low interrupt and sync request.
 * Assumes the control port presents single-cycle decoded accesses and that
 * per-lane sources come from the lane status logic on the same clock.
 */
module dlci_top #(
    parameter int unsigned LANES = 8
) (
    // Clock and reset
    input  wire logic                  ref_clk_i,
    input  wire logic                  rst_b_i,
    // Register port
    input  wire dlci_pkg::dlci_reg_req_s reg_req_i,
    output dlci_pkg::dlci_reg_rsp_s      reg_rsp_o,
    // Per-lane error sources
    input  wire logic [LANES-1:0]      disparity_err_lane_i,
    input  wire logic [LANES-1:0]      table_miss_lane_i,
    input  wire logic [LANES-1:0]      stray_control_lane_i,
    input  wire logic [LANES-1:0]      lane_align_fail_lane_i,
    input  wire logic [LANES-1:0]      checksum_fail_lane_i,
    input  wire logic [LANES-1:0]      frame_lock_fail_lane_i,
    input  wire logic [LANES-1:0]      group_lock_fail_lane_i,
    // Sync-request gates: disparity, table miss, stray control
    input  wire logic [2:0]            sync_req_gate_i,
    // Configuration out to the deframer
    output logic [7:0]                 octets_per_frame_o,
    output logic                       alignment_test_mode_o,
    output logic                       threshold_gate_en_o,
    output logic [9:0]                 alignment_multiframes_o,
    // Link and host signalling
    output logic                       link_sync_request_o,
    output logic                       irq_b_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Source aggregation
    logic [dlci_pkg::NUM_SOURCES-1:0][LANES-1:0] lane_src;
    logic [dlci_pkg::NUM_SOURCES-1:0]            any_lane;

    always_comb begin
        lane_src = '0;
        lane_src[dlci_pkg::BIT_DISPARITY_ERR]   = disparity_err_lane_i;
        lane_src[dlci_pkg::BIT_TABLE_MISS]      = table_miss_lane_i;
        lane_src[dlci_pkg::BIT_STRAY_CONTROL]   = stray_control_lane_i;
        lane_src[dlci_pkg::BIT_LANE_ALIGN_FAIL] = lane_align_fail_lane_i;
        lane_src[dlci_pkg::BIT_CHECKSUM_FAIL]   = checksum_fail_lane_i;
        lane_src[dlci_pkg::BIT_FRAME_LOCK_FAIL] = frame_lock_fail_lane_i;
        lane_src[dlci_pkg::BIT_GROUP_LOCK_FAIL] = group_lock_fail_lane_i;
    end

    dlci_lane_or #(
        .LANES      (LANES)
    ) u_lane_or (
        .lane_src_i (lane_src),
        .any_lane_o (any_lane)
    );

    ////////////////////////////////////////////////////////////////////////////
    // State
    dlci_pkg::dlci_state_s state_q;
    dlci_pkg::dlci_state_s state_d;

    logic       wr_hit_octets;
    logic       wr_hit_test;
    logic       wr_hit_align;
    logic       wr_hit_irq;
    logic       octets_legal;
    logic [7:0] pending_next;
    logic       gate_en;

    always_comb begin
        state_d = state_q;

        wr_hit_octets = reg_req_i.wr && (reg_req_i.addr == dlci_pkg::OFS_OCTETS_PER_FRAME);
        wr_hit_test   = reg_req_i.wr && (reg_req_i.addr == dlci_pkg::OFS_LINK_TEST_CTRL);
        wr_hit_align  = reg_req_i.wr && (reg_req_i.addr == dlci_pkg::OFS_ALIGN_MF_COUNT);
        wr_hit_irq    = reg_req_i.wr && (reg_req_i.addr == dlci_pkg::OFS_LINK_IRQ_VECTOR);

        // Illegal frame sizes are dropped so the deframer never sees one
        octets_legal = (reg_req_i.wdata == dlci_pkg::OCTETS_ONE)  ||
                       (reg_req_i.wdata == dlci_pkg::OCTETS_TWO)  ||
                       (reg_req_i.wdata == dlci_pkg::OCTETS_FOUR);
        if (wr_hit_octets && octets_legal) begin
            state_d.octets_per_frame = reg_req_i.wdata;
        end
        if (wr_hit_test) begin
            state_d.link_test_ctrl = reg_req_i.wdata;
        end
        // Zero would give an empty alignment sequence; keep the old length
        if (wr_hit_align && (reg_req_i.wdata != 8'h00)) begin
            state_d.alignment_multiframes_div4 = reg_req_i.wdata;
        end
        if (wr_hit_irq) begin
            state_d.link_irq_enable = reg_req_i.wdata & dlci_pkg::IRQ_VECTOR_USED;
        end

        // Flags follow the sources; cleared only by clearing the lane source
        pending_next = any_lane & dlci_pkg::IRQ_VECTOR_USED;
        state_d.link_irq_pending = pending_next;

        // One-cycle lag from flag to pin keeps the pin flop-driven
        state_d.irq_n = ~|(state_q.link_irq_pending & state_q.link_irq_enable);

        // Per-error gates only count while the threshold gate is on
        gate_en = state_q.link_test_ctrl[dlci_pkg::BIT_THRESHOLD_GATE_EN];
        state_d.link_sync_request = gate_en && (
            (sync_req_gate_i[dlci_pkg::GATE_DISPARITY] &&
             state_q.link_irq_pending[dlci_pkg::BIT_DISPARITY_ERR]) ||
            (sync_req_gate_i[dlci_pkg::GATE_TABLE] &&
             state_q.link_irq_pending[dlci_pkg::BIT_TABLE_MISS]) ||
            (sync_req_gate_i[dlci_pkg::GATE_STRAY] &&
             state_q.link_irq_pending[dlci_pkg::BIT_STRAY_CONTROL]));

        state_d.alignment_multiframes =
            {2'b00, state_d.alignment_multiframes_div4} << dlci_pkg::ALIGN_MF_SHIFT;

        // Read answer one cycle after the request; unmapped reads give zero
        state_d.rsp.valid = reg_req_i.rd;
        state_d.rsp.rdata = 8'h00;
        if (reg_req_i.rd) begin
            case (reg_req_i.addr)
                dlci_pkg::OFS_OCTETS_PER_FRAME: begin
                    state_d.rsp.rdata = state_q.octets_per_frame;
                end
                dlci_pkg::OFS_LINK_TEST_CTRL: begin
                    state_d.rsp.rdata = state_q.link_test_ctrl;
                end
                dlci_pkg::OFS_ALIGN_MF_COUNT: begin
                    state_d.rsp.rdata = state_q.alignment_multiframes_div4;
                end
                dlci_pkg::OFS_LINK_IRQ_VECTOR: begin
                    state_d.rsp.rdata = state_q.link_irq_pending;
                end
                default: begin
                    state_d.rsp.rdata = 8'h00;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_q.octets_per_frame           <= dlci_pkg::RST_OCTETS_PER_FRAME;
            state_q.link_test_ctrl             <= dlci_pkg::RST_LINK_TEST_CTRL;
            state_q.alignment_multiframes_div4 <= dlci_pkg::RST_ALIGN_MF_COUNT;
            state_q.link_irq_enable            <= dlci_pkg::RST_LINK_IRQ_ENABLE;
            state_q.link_irq_pending           <= 8'h00;
            state_q.irq_n                      <= 1'b1;
            state_q.link_sync_request          <= 1'b0;
            state_q.alignment_multiframes      <= 10'h004;
            state_q.rsp                        <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign reg_rsp_o               = state_q.rsp;
    assign octets_per_frame_o      = state_q.octets_per_frame;
    assign alignment_test_mode_o   = state_q.link_test_ctrl[dlci_pkg::BIT_ALIGNMENT_TEST_MODE];
    assign threshold_gate_en_o     = state_q.link_test_ctrl[dlci_pkg::BIT_THRESHOLD_GATE_EN];
    assign alignment_multiframes_o = state_q.alignment_multiframes;
    assign link_sync_request_o     = state_q.link_sync_request;
    // Enables at bits 7..5 and 3..0 each steer one flag onto the pin; bit 4 is held at zero
    assign irq_b_o                 = state_q.irq_n;

endmodule : dlci_top

/* File: dv/dlci_top_asserts.sv */
/* Port checker for dlci_top, bound at the foot; assumes one clock and one reset domain. */
module dlci_top_asserts #(parameter int unsigned LANES = 8) (
    // Clock, reset and register port
    input wire logic                    ref_clk_i, rst_b_i,
    input wire dlci_pkg::dlci_reg_req_s reg_req_i,
    input wire dlci_pkg::dlci_reg_rsp_s reg_rsp_o,
    // Lane sources, gates and outputs
    input wire logic [LANES-1:0] disparity_err_lane_i, table_miss_lane_i, stray_control_lane_i,
    input wire logic [LANES-1:0] lane_align_fail_lane_i, checksum_fail_lane_i,
    input wire logic [LANES-1:0] frame_lock_fail_lane_i, group_lock_fail_lane_i,
    input wire logic [2:0]       sync_req_gate_i,
    input wire logic [7:0]       octets_per_frame_o,
    input wire logic [9:0]       alignment_multiframes_o,
    input wire logic alignment_test_mode_o, threshold_gate_en_o, link_sync_request_o, irq_b_o
);
    timeunit 1ns / 1ps;
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_b_i);
    logic any_w;
    // Any lane of any class in error
    assign any_w = |{disparity_err_lane_i, table_miss_lane_i, stray_control_lane_i,
        lane_align_fail_lane_i, checksum_fail_lane_i, frame_lock_fail_lane_i,
        group_lock_fail_lane_i};
    ////////////////////////////////////////////////////////////////////////////////
    property p_rd_valid; reg_req_i.rd |=> reg_rsp_o.valid; endproperty
    a_rd_valid: assert property (p_rd_valid) else $error("read not answered");
    property p_frame_ok; octets_per_frame_o inside {8'h01, 8'h02, 8'h04}; endproperty
    a_frame_ok: assert property (p_frame_ok) else $error("frame size illegal");
    property p_frame_wr; reg_req_i.wr && reg_req_i.addr == 12'h476 && reg_req_i.wdata inside
        {8'h01, 8'h02, 8'h04} |=> octets_per_frame_o == $past(reg_req_i.wdata); endproperty
    a_frame_wr: assert property (p_frame_wr) else $error("frame size not taken");
    property p_mf_wr; reg_req_i.wr && reg_req_i.addr == 12'h478 && reg_req_i.wdata != 8'h00
        |=> alignment_multiframes_o == {$past(reg_req_i.wdata), 2'h0}; endproperty
    a_mf_wr: assert property (p_mf_wr) else $error("sequence length wrong");
    property p_mode_wr; reg_req_i.wr && reg_req_i.addr == 12'h477
        |=> alignment_test_mode_o == $past(reg_req_i.wdata[7]); endproperty
    a_mode_wr: assert property (p_mode_wr) else $error("test mode wrong");
    property p_irq_idle; (!any_w) [*2] |=> irq_b_o; endproperty
    a_irq_idle: assert property (p_irq_idle) else $error("interrupt without source");
    property p_sync_set; (sync_req_gate_i[2] && threshold_gate_en_o && |disparity_err_lane_i)
        [*3] |-> link_sync_request_o; endproperty
    a_sync_set: assert property (p_sync_set) else $error("sync request missing");
    property p_sync_idle; (sync_req_gate_i == 3'h0) [*2] |=> !link_sync_request_o; endproperty
    a_sync_idle: assert property (p_sync_idle) else $error("sync request ungated");
    cover property (reg_req_i.rd && reg_req_i.addr == 12'h47A);
    cover property (!irq_b_o);
    cover property (link_sync_request_o);
endmodule : dlci_top_asserts
////////////////////////////////////////////////////////////////////////////////
bind dlci_top dlci_top_asserts #(.LANES(LANES)) dlci_top_asserts_i (.*);

/* File: dv/dlci_lane_model.sv */
/* Far-side lane status model holding per-lane error levels until dropped;
   assumes one bench command per clock, row 6 disparity down to row 0 group lock. */
module dlci_lane_model (
    // Clock, reset and command
    input  wire logic            ref_clk_i, rst_b_i, set_i, lvl_i,
    input  wire logic [2:0]      row_i, lane_i,
    // Held sources
    output logic      [6:0][7:0] src_o
);
    timeunit 1ns / 1ps;
    // Levels persist, as the real lane logic keeps them until its own clear
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) src_o <= 56'h0;
        else if (set_i) src_o[row_i][lane_i] <= lvl_i;
    end
endmodule : dlci_lane_model

/* File: dv/test_deframer_link_cfg_irq_vector.sv */
/* Bench for dlci_top: register calls and lane events against expected values;
   assumes the lane model and the bound checker are compiled alongside. */
module test_deframer_link_cfg_irq_vector;
    timeunit 1ns / 1ps;
    logic clk, rst_b, set, lvl, tmode, gen, sync, irq_b;
    logic [2:0] gate, row, lane;
    logic [7:0] opf, e, b;
    logic [9:0] mf, iq;
    logic [7:0] fs[5] = '{8'h02, 8'h03, 8'h04, 8'h00, 8'h01};
    logic [6:0][7:0] src;
    dlci_pkg::dlci_reg_req_s req;
    dlci_pkg::dlci_reg_rsp_s rsp;
    int n_fail = 0;
    int n_tests = 0;
    assign iq = 10'(irq_b);
    always #2 clk = ~clk;
    dlci_top dlci_top_i (.ref_clk_i(clk), .rst_b_i(rst_b), .reg_req_i(req), .reg_rsp_o(rsp),
        .disparity_err_lane_i(src[6]), .table_miss_lane_i(src[5]), .stray_control_lane_i(src[4]),
        .lane_align_fail_lane_i(src[3]), .checksum_fail_lane_i(src[2]),
        .frame_lock_fail_lane_i(src[1]), .group_lock_fail_lane_i(src[0]), .sync_req_gate_i(gate),
        .octets_per_frame_o(opf), .alignment_test_mode_o(tmode), .threshold_gate_en_o(gen),
        .alignment_multiframes_o(mf), .link_sync_request_o(sync), .irq_b_o(irq_b));
    dlci_lane_model dlci_lane_model_i (.ref_clk_i(clk), .rst_b_i(rst_b), .set_i(set),
        .lvl_i(lvl), .row_i(row), .lane_i(lane), .src_o(src));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(string nm, logic [9:0] seen, logic [9:0] exp);
        n_tests++;
        n_fail += int'(seen !== exp);
        if (seen !== exp) $display("ERROR %s expected %h seen %h", nm, exp, seen);
    endtask : chk
    // Idle edge after each strobe so the next call never reassigns in one step
    task automatic wr(logic [11:0] a, logic [7:0] d);
        req = '{1'b1, 1'b0, a, d};
        @(posedge clk) #1 req = '{1'b0, 1'b0, a, d};
        @(posedge clk) #1;
    endtask : wr
    // Response stands one cycle only, so it is looked at right away
    task automatic rd(logic [11:0] a, logic [7:0] x);
        req = '{1'b0, 1'b1, a, 8'h00};
        @(posedge clk) #1 req = '{1'b0, 1'b0, a, 8'h00};
        chk("rdata", {1'b0, rsp}, {2'h1, x});
        @(posedge clk) #1;
    endtask : rd
    task automatic ev(logic [2:0] r, logic [2:0] l, logic v);
        {set, row, lane, lvl} = {1'b1, r, l, v};
        @(posedge clk) #1 set = 1'b0;
        repeat (2) @(posedge clk) #1;
    endtask : ev
    task automatic conclude;
        $display("Checks %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : conclude
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {clk, rst_b, set, lvl, gate, row, lane} = 13'h0000;
        req = '{1'b0, 1'b0, 12'h000, 8'h00};
        repeat (12) @(posedge clk);
        #1 rst_b = 1'b1;
        rd(12'h476, 8'h01);
        rd(12'h477, 8'h00);
        rd(12'h478, 8'h01);
        rd(12'h47A, 8'h00);
        rd(12'h479, 8'h00);
        e = 8'h01;
        foreach (fs[i]) begin
            wr(12'h476, fs[i]);
            if (fs[i] inside {8'h01, 8'h02, 8'h04}) e = fs[i];
            chk("octets", 10'(opf), 10'(e));
            rd(12'h476, e);
        end
        wr(12'h478, 8'h00);
        chk("alignment_multiframe_count", mf, 10'h004);
        wr(12'h478, 8'hFF);
        chk("alignment_multiframe_count", mf, 10'h3FC);
        wr(12'h477, 8'h80);
        chk("mode", 10'({tmode, gen}), 10'h002);
        wr(12'h477, 8'h08);
        chk("mode", 10'({tmode, gen}), 10'h001);
        wr(12'h47A, 8'hFF);
        rd(12'h47A, 8'h00);
        // Each class alone on its own lane: masked first, then enabled, then dropped
        for (int r = 0; r < 7; r++) begin
            b = 8'h01 << (r + int'(r > 3));
            wr(12'h47A, ~b);
            ev(3'(r), 3'(6 - r), 1'b1);
            chk("irq", iq, 10'h001);
            rd(12'h47A, b);
            wr(12'h47A, b);
            repeat (2) @(posedge clk) #1;
            chk("irq", iq, 10'h000);
            ev(3'(r), 3'(6 - r), 1'b0);
            chk("irq", iq, 10'h001);
        end
        gate = 3'h4;
        ev(3'h6, 3'h7, 1'b1);
        repeat (2) @(posedge clk) #1;
        chk("sync", 10'(sync), 10'h001);
        gate = 3'h0;
        repeat (2) @(posedge clk) #1;
        chk("sync", 10'(sync), 10'h000);
        conclude;
    end
    // Whole run is well under a thousand cycles
    initial begin
        #20000 n_fail++;
        conclude;
    end
endmodule : test_deframer_link_cfg_irq_vector
